// [rtl/scc_clock_control.sv]
// System clock control: clock_control register, source switch, gating.
// Assumes a software strobe port on sys_clk and an idle flag from the core.
//
// Summary of operation
// R1: Fast clock type changes only in slow mode
// R2: Peripheral stop bit gates UART, timers when idle
// R3: Fast stop bit halts fast oscillator slow/idle
// R4: Fast stop bit changes only on slow clock
// R5: Source bit 0 slow, 1 fast; needs fast-stop 0
// R6: Prescaler 16/4/2/1, reset 11, within 16 cycles
// R7: Refused bit keeps value, other bits update
`timescale 1ns/1ps
module scc_clock_control
   import scc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // Core state
   input  wire logic       core_idle,
   // Oscillator pins
   input  wire logic       fast_osc_ready,
   output logic            fast_osc_en,
   output logic            slow_osc_en,
   output logic            fast_clock_type_sel,
   output logic            slow_clock_type_sel,
   // System clock
   output logic            sysclk_on_fast,
   output logic            sysclk_tick,
   // Peripheral clock enables
   output logic            uart_clk_en,
   output logic [2:0]      timer_clk_en
);

   typedef struct packed {
      logic          slow_type;
      logic          fast_type;
      logic          slow_stop;
      logic          periph_stop;
      logic          fast_stop;
      logic          src_sel;
      logic [1:0]    div;
      scc_sw_state_t sw;
      logic [2:0]    rdy_sync;
      logic          rdy;
      logic          blocked;
      logic [7:0]    rdata;
      logic          fast_en;
      logic          slow_en;
      logic          on_fast;
      logic          uart_en;
      logic [2:0]    timer_en;
   } scc_st_t;

   scc_st_t    st;
   scc_st_t    next_st;
   logic       div_tick;
   logic [1:0] div_active;

   logic       wr_ctrl;
   logic       rd_stat;
   logic       slow_mode;
   logic       refused;
   logic [7:0] ctrl_q;
   logic [7:0] stat_q;

   scc_divider u_divider (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .div_code    (st.div),
      .tick        (div_tick),
      .active_code (div_active)
   );

   always_comb begin
      ctrl_q = {st.slow_type, st.fast_type, st.slow_stop, st.periph_stop,
                st.fast_stop, st.src_sel, st.div};
      stat_q = 8'h00;
      stat_q[SCC_ST_FAST_READY_BIT]       = st.rdy;
      stat_q[SCC_ST_ON_FAST_BIT]          = st.on_fast;
      stat_q[SCC_ST_SWITCHING_BIT]        = (st.sw == SCC_SW_WAIT);
      stat_q[SCC_ST_BLOCKED_BIT]          = st.blocked;
      stat_q[SCC_ST_DIV_LSB +: 2]         = div_active;
   end

   always_comb begin
      next_st   = st;
      wr_ctrl   = reg_wr && (reg_addr == SCC_CLOCK_CONTROL_ADDR);
      rd_stat   = reg_rd && (reg_addr == SCC_CLOCK_STATUS_ADDR);
      // Slow mode: system clock really taken from the slow clock
      slow_mode = (st.sw == SCC_SW_SLOW);
      refused   = 1'b0;

      // Pin synchroniser; a change counts once stages two and three agree
      next_st.rdy_sync = {st.rdy_sync[1:0], fast_osc_ready};
      if (st.rdy_sync[1] == st.rdy_sync[2]) begin
         next_st.rdy = st.rdy_sync[2];
      end

      // Register write
      if (wr_ctrl) begin
         next_st.slow_type   = reg_wdata[SCC_SLOW_TYPE_BIT];
         next_st.slow_stop   = reg_wdata[SCC_SLOW_STOP_BIT];
         next_st.periph_stop = reg_wdata[SCC_PERIPH_STOP_BIT];
         next_st.div         = reg_wdata[SCC_DIV_LSB +: 2];       // R6
         if (slow_mode) begin
            next_st.fast_type = reg_wdata[SCC_FAST_TYPE_BIT];     // R1
         end else if (reg_wdata[SCC_FAST_TYPE_BIT] != st.fast_type) begin
            refused = 1'b1;                                       // R7
         end
         if (slow_mode) begin
            next_st.fast_stop = reg_wdata[SCC_FAST_STOP_BIT];     // R4
         end else if (reg_wdata[SCC_FAST_STOP_BIT] != st.fast_stop) begin
            refused = 1'b1;                                       // R7
         end
         if (!st.fast_stop) begin
            next_st.src_sel = reg_wdata[SCC_SRC_SEL_BIT];         // R5
         end else if (reg_wdata[SCC_SRC_SEL_BIT] != st.src_sel) begin
            refused = 1'b1;                                       // R7
         end
      end

      // Sticky refused-write flag; a new refusal wins over the read clear
      if (refused) begin
         next_st.blocked = 1'b1;
      end else if (rd_stat) begin
         next_st.blocked = 1'b0;
      end

      // Source switch; fast clock used only once its oscillator is ready
      case (st.sw)
         SCC_SW_SLOW: begin
            if (st.src_sel) begin
               next_st.sw = SCC_SW_WAIT;                          // R5
            end
         end
         SCC_SW_WAIT: begin
            if (!st.src_sel) begin
               next_st.sw = SCC_SW_SLOW;
            end else if (st.rdy) begin
               next_st.sw = SCC_SW_FAST;
            end
         end
         SCC_SW_FAST: begin
            if (!st.src_sel) begin
               next_st.sw = SCC_SW_SLOW;                          // R5
            end
         end
         default: begin
            next_st.sw = SCC_SW_SLOW;
         end
      endcase

      // Oscillator and peripheral enables
      next_st.fast_en  = !(st.fast_stop && (slow_mode || core_idle));   // R3
      next_st.slow_en  = !(st.slow_stop && (st.sw == SCC_SW_FAST));
      next_st.on_fast  = (next_st.sw == SCC_SW_FAST);
      next_st.uart_en  = !(st.periph_stop && core_idle);                 // R2
      next_st.timer_en = {3{!(st.periph_stop && core_idle)}};            // R2

      // Read data, one cycle after the strobe
      next_st.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == SCC_CLOCK_CONTROL_ADDR) begin
            next_st.rdata = ctrl_q;
         end else if (reg_addr == SCC_CLOCK_STATUS_ADDR) begin
            next_st.rdata = stat_q;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st.slow_type   <= SCC_CLOCK_CONTROL_RST[SCC_SLOW_TYPE_BIT];
         st.fast_type   <= SCC_CLOCK_CONTROL_RST[SCC_FAST_TYPE_BIT];
         st.slow_stop   <= SCC_CLOCK_CONTROL_RST[SCC_SLOW_STOP_BIT];
         st.periph_stop <= SCC_CLOCK_CONTROL_RST[SCC_PERIPH_STOP_BIT];
         st.fast_stop   <= SCC_CLOCK_CONTROL_RST[SCC_FAST_STOP_BIT];
         st.src_sel     <= SCC_CLOCK_CONTROL_RST[SCC_SRC_SEL_BIT];
         st.div         <= SCC_DIV_RST;                                   // R6
         st.sw          <= SCC_SW_SLOW;
         st.rdy_sync    <= 3'h0;
         st.rdy         <= 1'b0;
         st.blocked     <= 1'b0;
         st.rdata       <= 8'h00;
         st.fast_en     <= 1'b1;
         st.slow_en     <= 1'b1;
         st.on_fast     <= 1'b0;
         st.uart_en     <= 1'b1;
         st.timer_en    <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata           = st.rdata;
   assign fast_osc_en         = st.fast_en;
   assign slow_osc_en         = st.slow_en;
   assign fast_clock_type_sel = st.fast_type;
   assign slow_clock_type_sel = st.slow_type;
   assign sysclk_on_fast      = st.on_fast;
   assign sysclk_tick         = div_tick;
   assign uart_clk_en         = st.uart_en;
   assign timer_clk_en        = st.timer_en;

endmodule : scc_clock_control

// [rtl/scc_divider.sv]
// System clock prescaler: one-cycle tick every 16, 4, 2 or 1 cycles.
// Assumes the prescaler code comes from logic on the same clock.
`timescale 1ns/1ps
module scc_divider
   import scc_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Requested setting
   input  wire logic [1:0] div_code,
   // Divided output
   output logic            tick,
   output logic [1:0]      active_code
);

   typedef struct packed {
      logic [3:0] cnt;
      logic [1:0] code;
      logic       tick;
   } scc_div_st_t;

   scc_div_st_t st;
   scc_div_st_t next_st;

   always_comb begin
      next_st = st;
      if (st.cnt == 4'h0) begin
         // New code taken only at a period boundary
         next_st.code = div_code;                              // R6
         next_st.cnt  = scc_div_reload(div_code);              // R6
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt  = st.cnt - 4'h1;
         next_st.tick = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{cnt: 4'h0, code: SCC_DIV_RST, tick: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign tick        = st.tick;
   assign active_code = st.code;

endmodule : scc_divider

// [rtl/scc_pkg.sv]
// System clock control package: register map, fields, reset values, states.
// Assumes one 40 MHz clock and a plain strobe register port.
package scc_pkg;

   // Register offsets
   localparam logic [7:0] SCC_CLOCK_CONTROL_ADDR = 8'hd8;
   localparam logic [7:0] SCC_CLOCK_STATUS_ADDR  = 8'hd9;

   // clock_control field positions
   localparam int SCC_SLOW_TYPE_BIT   = 7;
   localparam int SCC_FAST_TYPE_BIT   = 6;
   localparam int SCC_SLOW_STOP_BIT   = 5;
   localparam int SCC_PERIPH_STOP_BIT = 4;
   localparam int SCC_FAST_STOP_BIT   = 3;
   localparam int SCC_SRC_SEL_BIT     = 2;
   localparam int SCC_DIV_LSB         = 0;

   // clock_status field positions
   localparam int SCC_ST_FAST_READY_BIT = 0;
   localparam int SCC_ST_ON_FAST_BIT    = 1;
   localparam int SCC_ST_SWITCHING_BIT  = 2;
   localparam int SCC_ST_BLOCKED_BIT    = 3;
   localparam int SCC_ST_DIV_LSB        = 4;

   // Reset values
   localparam logic [7:0] SCC_CLOCK_CONTROL_RST = 8'h23;
   localparam logic [1:0] SCC_DIV_RST           = 2'h3;

   // Prescaler codes
   localparam logic [1:0] SCC_DIV16 = 2'h0;
   localparam logic [1:0] SCC_DIV4  = 2'h1;
   localparam logic [1:0] SCC_DIV2  = 2'h2;
   localparam logic [1:0] SCC_DIV1  = 2'h3;

   // Longest wait before a new prescaler setting applies, in cycles
   localparam int SCC_DIV_APPLY_MAX_CYCLES = 16;

   // Clock source switch states
   typedef enum logic [2:0] {
      SCC_SW_SLOW = 3'h1,
      SCC_SW_WAIT = 3'h2,
      SCC_SW_FAST = 3'h4
   } scc_sw_state_t;

   // Cycles between ticks minus one for a prescaler code
   function automatic logic [3:0] scc_div_reload(input logic [1:0] code);
      case (code)
         SCC_DIV16: scc_div_reload = 4'hf;
         SCC_DIV4:  scc_div_reload = 4'h3;
         SCC_DIV2:  scc_div_reload = 4'h1;
         default:   scc_div_reload = 4'h0;
      endcase
   endfunction : scc_div_reload

endpackage : scc_pkg

// [tb/scc_chk.sv]
// Checker: port assertions for the clock control block.
// Assumes a bind onto scc_clock_control.
`timescale 1ns/1ps
module scc_chk
   import scc_pkg::*;
(
   // Clock, reset, bus
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Clock side
   input wire logic       core_idle,
   input wire logic       fast_osc_ready,
   input wire logic       fast_osc_en,
   input wire logic       fast_clock_type_sel,
   input wire logic       slow_clock_type_sel,
   input wire logic       sysclk_on_fast,
   input wire logic       sysclk_tick,
   input wire logic       uart_clk_en,
   input wire logic [2:0] timer_clk_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic       pstop;
   logic [4:0] gap;
   wire        wr_cc = reg_wr && reg_addr == SCC_CLOCK_CONTROL_ADDR;
   // Shadow of the unrestricted idle stop bit, tick gap count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pstop <= 1'b0;
         gap   <= 5'h0;
      end else begin
         if (wr_cc) pstop <= reg_wdata[SCC_PERIPH_STOP_BIT];
         gap <= sysclk_tick ? 5'h0 : gap + 5'h1;
      end
   end
   property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h0; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
   property p_type_slow; wr_cc |=> slow_clock_type_sel == $past(reg_wdata[7]); endproperty
   a_type_slow: assert property (p_type_slow) else $error("slow type bit missed write");
   property p_type_fast;
      $changed(fast_clock_type_sel) |-> $past(wr_cc) && !$past(sysclk_on_fast);
   endproperty
   a_type_fast: assert property (p_type_fast) else $error("fast type changed off slow");
   property p_idle_gate; pstop && core_idle |=> !uart_clk_en; endproperty
   a_idle_gate: assert property (p_idle_gate) else $error("uart clock not gated");
   property p_run_on; !core_idle |=> uart_clk_en && timer_clk_en == 3'h7; endproperty
   a_run_on: assert property (p_run_on) else $error("peripheral clocks gated when running");
   property p_gate_same; timer_clk_en == {3{uart_clk_en}}; endproperty
   a_gate_same: assert property (p_gate_same) else $error("timer and uart gates differ");
   property p_fast_off; $fell(fast_osc_en) |-> $past(core_idle) || !$past(sysclk_on_fast); endproperty
   a_fast_off: assert property (p_fast_off) else $error("fast clock stopped while running on it");
   property p_on_fast; $rose(sysclk_on_fast) |-> $past(fast_osc_ready, 3) && fast_osc_en; endproperty
   a_on_fast: assert property (p_on_fast) else $error("switched to unready fast clock");
   property p_tick_gap; gap <= 5'hf; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick gap above sixteen");
   c_fast: cover property ($rose(sysclk_on_fast));
   c_gate: cover property ($fell(uart_clk_en));
   c_stop: cover property ($fell(fast_osc_en));
endmodule : scc_chk

bind scc_clock_control scc_chk i_chk (.*);

// [tb/scc_clock_control_tb_top.sv]
// Self-checking bench for the clock control block.
// Assumes the bound checker and a 40 MHz clock.
`timescale 1ns/1ps
module scc_clock_control_tb_top;
   import scc_pkg::*;
   logic       sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
   logic       core_idle = 0, fast_osc_ready = 1;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
   logic       fast_osc_en, slow_osc_en, fast_clock_type_sel, slow_clock_type_sel;
   logic       sysclk_on_fast, sysclk_tick, uart_clk_en;
   logic [2:0] timer_clk_en;
   int         err_count = 0, n_tests = 0;
   scc_clock_control i_dut (.*);
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd <= 1; reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic t_reset;
      rd(SCC_CLOCK_CONTROL_ADDR, d); chk(d, 8'h23);
      rd(8'hd0, d); chk(d, 8'h00);
      chk({5'h0, timer_clk_en}, 8'h07);
      $display("reset test done");
   endtask : t_reset
   task automatic t_slow;
      wr(SCC_CLOCK_CONTROL_ADDR, 8'he3); chk(fast_clock_type_sel, 1'b1);
      chk(slow_clock_type_sel, 1'b1);
      chk(slow_osc_en, 1'b1);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h2b); cyc(3); chk(fast_osc_en, 1'b0);
      rd(SCC_CLOCK_CONTROL_ADDR, d); chk(d, 8'h2b);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h2f); cyc(8); chk(sysclk_on_fast, 1'b0);
      rd(SCC_CLOCK_CONTROL_ADDR, d); chk(d, 8'h2b);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h23); cyc(3); chk(fast_osc_en, 1'b1);
      $display("slow mode test done");
   endtask : t_slow
   task automatic t_fast;
      int n;
      @(posedge sys_clk);
      fast_osc_ready <= 0;
      cyc(6);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h27); cyc(6); chk(sysclk_on_fast, 1'b0);
      rd(SCC_CLOCK_STATUS_ADDR, d); chk(d, 8'h3c);
      @(posedge sys_clk);
      fast_osc_ready <= 1;
      for (n = 0; n < 20 && sysclk_on_fast !== 1'b1; n++) cyc(1);
      chk(sysclk_on_fast, 1'b1);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'hef); chk(fast_clock_type_sel, 1'b0);
      rd(SCC_CLOCK_CONTROL_ADDR, d); chk(d, 8'ha7);
      chk(slow_osc_en, 1'b0);
      rd(SCC_CLOCK_STATUS_ADDR, d); chk(d, 8'h3b);
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h23);
      for (n = 0; n < 20 && sysclk_on_fast !== 1'b0; n++) cyc(1);
      chk(sysclk_on_fast, 1'b0);
      $display("fast mode test done");
   endtask : t_fast
   task automatic t_idle;
      wr(SCC_CLOCK_CONTROL_ADDR, 8'h33);
      @(posedge sys_clk);
      core_idle <= 1;
      cyc(3);
      chk({uart_clk_en, timer_clk_en}, 8'h00);
      @(posedge sys_clk);
      core_idle <= 0;
      cyc(3);
      chk({uart_clk_en, timer_clk_en}, 8'h0f);
      $display("idle gating test done");
   endtask : t_idle
   task automatic t_div;
      logic [4:0] want[4] = '{5'd16, 5'd4, 5'd2, 5'd1};
      int n;
      for (int i = 0; i < 4; i++) begin
         wr(SCC_CLOCK_CONTROL_ADDR, 8'h20 | 8'(i)); cyc(SCC_DIV_APPLY_MAX_CYCLES + 1);
         for (n = 0; n < 20 && sysclk_tick !== 1'b1; n++) cyc(1);
         n = 0;
         do begin cyc(1); n++; end while (sysclk_tick !== 1'b1 && n < 20);
         chk(8'(n), {3'h0, want[i]});
      end
      $display("prescaler test done");
   endtask : t_div
   task automatic end_of_test;
      $display("tests %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      #(25 * 5000);
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1;
      t_reset(); t_slow(); t_fast(); t_idle(); t_div();
      end_of_test();
   end
endmodule : scc_clock_control_tb_top
